// ===== tpg_one_shot_timer.sv
// Prescaled down-counting timer with waveform and one-shot pulse output
`timescale 1ns/1ns
// How it works
// - Level bit sets primary, secondary, stopped waveform levels
// - Switch bit picks waveform or port latch
// - Edge bit picks falling or rising trigger edge; both-edges bit makes both edges trigger
// - One-shot pulse is (prescaler+1)(primary+1) source periods
// - One-shot underflow reloads and clears active flag
// - Stopping a one-shot reloads the counters first
// - Start bit or qualified pin edge triggers
// - One-shot ends on underflow, stop, run off, halt
// - One-shot interrupt coincides with pulse end
// - Trigger enable lets pin act as trigger
// - Prescaler and primary writes while stopped also load counters
// - Triggers only act while counting status set
// - Active flag sets one to two source cycles later
// - Triggers while active are ignored
// - Trigger edge bit never affects pin interrupt
// - Ignored pin trigger still sets pin request flag
// - Wait one-shot waits primary count, then secondary
// - Wait pulse is secondary count, then clears active
// - Wait interrupt coincides with pulse end
// - Forced halt stops at once, no sync delay

module tpg_one_shot_timer
  import tpg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_ext_count_tick,
  input wire logic i_ext_trigger_pin,
  output logic o_pulse_output_pin,
  output logic o_timer_irq,
  output logic o_pin_irq_request
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic edge_hit(input logic rise, input logic fall,
                                    input logic both, input logic dir);
    edge_hit = both ? (rise | fall) : (dir ? rise : fall);
  endfunction : edge_hit

  tpg_state_t s;
  tpg_state_t next_s;

  logic req;
  logic wr_take;
  logic wr_lane;
  logic [9:0] idx;
  logic [7:0] wd;
  logic cs_tick;
  logic rise;
  logic fall;
  logic sw_trig;
  logic halt;
  logic trig;
  logic one_shot_mode;
  logic [7:0] rd_byte;
  logic wave_level;
  logic pulse_level;

  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~s.ack;
  assign o_avs_readdata = s.rdata;
  assign o_pulse_output_pin = s.out_pin;
  assign o_timer_irq = s.timer_irq;
  assign o_pin_irq_request = s.irq_pending;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.timer_irq = 1'b0;
    next_s.ack = 1'b0;
    idx = i_avs_address[ADDR_W-1:2];
    wd = i_avs_writedata[7:0];
    wr_take = i_avs_write & s.ack;
    wr_lane = wr_take & i_avs_byteenable[0];
    sw_trig = 1'b0;
    halt = 1'b0;
    one_shot_mode = (s.mode == MODE_ONE_SHOT) ||
                    (s.mode == MODE_WAIT_ONE_SHOT);

    // Count source: one-cycle enable from the divider or outside tick
    next_s.div_cnt = s.div_cnt + 3'h1;
    case (s.src_sel)
      SRC_F1: cs_tick = 1'b1;
      SRC_F2: cs_tick = (s.div_cnt[0] == DIV2_LAST[0]);
      SRC_F8: cs_tick = (s.div_cnt == DIV8_LAST);
      SRC_EXT: cs_tick = i_ext_count_tick;
      default: cs_tick = 1'b0;
    endcase

    rise = i_ext_trigger_pin & ~s.pin_prev;
    fall = ~i_ext_trigger_pin & s.pin_prev;
    next_s.pin_prev = i_ext_trigger_pin;

    // Read data is captured on the first cycle and held while ack
    rd_byte = 8'h00;
    case (idx)
      IDX_TIMER_PIN_IO_CONTROL: rd_byte = {4'h0, s.io[3:0]};
      IDX_TIMER_RUN_CONTROL_REG: rd_byte = {6'h00, s.counting, s.run};
      IDX_ONE_SHOT_CONTROL_REG: rd_byte = {5'h00, s.active, 2'h0};
      IDX_MODE_REG: rd_byte = {4'h0, s.src_sel, s.mode};
      IDX_PRESCALER_SETTING: rd_byte = s.pre_cnt;
      IDX_PRIMARY_COUNT_SETTING: rd_byte = s.tmr_cnt;
      IDX_SECONDARY_COUNT_SETTING: rd_byte = s.sec_rel;
      IDX_PIN_IRQ_CONTROL_REG:
        rd_byte = {4'h0, s.irq_pending, s.edge_dir, s.both_edges, s.irq_en};
      IDX_SHARED_PORT_LATCH: rd_byte = {7'h00, s.port_latch};
      default: rd_byte = 8'h00;
    endcase
    if (req && !s.ack) begin
      next_s.ack = 1'b1;
      next_s.rdata = {24'h000000, rd_byte};
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (wr_lane) begin
      case (idx)
        IDX_TIMER_PIN_IO_CONTROL: next_s.io = {4'h0, wd[3:0]};
        IDX_TIMER_RUN_CONTROL_REG: begin
          if (wd[FORCED_HALT_BIT]) begin
            halt = 1'b1;
          end else begin
            next_s.run = wd[RUN_REQUEST_BIT];
          end
        end
        IDX_ONE_SHOT_CONTROL_REG: begin
          sw_trig = wd[ONE_SHOT_START_BIT];
          if (wd[ONE_SHOT_STOP_BIT]) begin
            next_s.stop_pend = 1'b1;
          end
        end
        IDX_MODE_REG: begin
          next_s.mode = tpg_mode_t'(wd[1:0]);
          next_s.src_sel = tpg_src_t'(wd[3:2]);
        end
        IDX_PRESCALER_SETTING: begin
          next_s.pre_rel = wd;
          if (!s.counting) begin
            next_s.pre_cnt = wd;
          end
        end
        IDX_PRIMARY_COUNT_SETTING: begin
          next_s.pri_rel = wd;
          if (!s.counting) begin
            next_s.tmr_cnt = wd;
          end
        end
        IDX_SECONDARY_COUNT_SETTING: next_s.sec_rel = wd;
        IDX_PIN_IRQ_CONTROL_REG: begin
          next_s.irq_en = wd[PIN_IRQ_ENABLE_BIT];
          next_s.both_edges = wd[BOTH_EDGES_BIT];
          next_s.edge_dir = wd[EDGE_DIRECTION_BIT];
          if (!wd[REQUEST_PENDING_BIT]) begin
            next_s.irq_pending = 1'b0;
          end
        end
        IDX_SHARED_PORT_LATCH: next_s.port_latch = wd[0];
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // Pin interrupt and trigger qualification
    // ----------------------------------------------------------------
    // Own polarity controls only; set after the clear so an edge wins
    if (s.irq_en && edge_hit(rise, fall, s.both_edges, s.edge_dir)) begin
      next_s.irq_pending = 1'b1;
    end

    trig = sw_trig | (s.io.pin_trigger_enable &
           edge_hit(rise, fall, s.both_edges,
                    s.io.pin_trigger_edge_sel));
    if (trig && s.counting && !s.active && one_shot_mode) begin
      next_s.trig_pend = 1'b1;
    end

    // ----------------------------------------------------------------
    // Counting engine, advanced once per count source tick
    // ----------------------------------------------------------------
    if (halt) begin
      // Bypasses the tick so the halt is seen on this very edge
      next_s.run = 1'b0;
      next_s.counting = 1'b0;
      next_s.active = 1'b0;
      next_s.trig_pend = 1'b0;
      next_s.stop_pend = 1'b0;
      next_s.pre_cnt = next_s.pre_rel;
      next_s.tmr_cnt = next_s.pri_rel;
      next_s.phase = PH_PRIMARY;
    end else if (cs_tick) begin
      if (s.run != s.counting) begin
        // Run bit reaches the status flag on the next source tick
        next_s.counting = s.run;
        next_s.eff_switch = s.io.output_source_switch;
        if (!s.run) begin
          next_s.active = 1'b0;
          next_s.trig_pend = 1'b0;
          next_s.stop_pend = 1'b0;
          next_s.pre_cnt = next_s.pre_rel;
          next_s.tmr_cnt = next_s.pri_rel;
          next_s.phase = PH_PRIMARY;
        end
      end else if (s.counting) begin
        if (s.stop_pend) begin
          next_s.stop_pend = 1'b0;
          next_s.trig_pend = 1'b0;
          next_s.active = 1'b0;
          next_s.pre_cnt = next_s.pre_rel;
          next_s.tmr_cnt = next_s.pri_rel;
          next_s.phase = PH_PRIMARY;
        end else if (s.trig_pend) begin
          next_s.trig_pend = 1'b0;
          next_s.active = 1'b1;
        end else if (!one_shot_mode || s.active) begin
          if (s.pre_cnt != 8'h00) begin
            next_s.pre_cnt = s.pre_cnt - 8'h01;
          end else begin
            next_s.pre_cnt = next_s.pre_rel;
            if (s.tmr_cnt != 8'h00) begin
              next_s.tmr_cnt = s.tmr_cnt - 8'h01;
            end else begin
              case (s.mode)
                MODE_WAVE: begin
                  if (s.phase == PH_PRIMARY) begin
                    next_s.phase = PH_SECONDARY;
                    next_s.tmr_cnt = next_s.sec_rel;
                  end else begin
                    next_s.phase = PH_PRIMARY;
                    next_s.tmr_cnt = next_s.pri_rel;
                    next_s.timer_irq = 1'b1;
                    next_s.eff_switch = s.io.output_source_switch;
                  end
                end
                MODE_ONE_SHOT: begin
                  next_s.tmr_cnt = next_s.pri_rel;
                  next_s.active = 1'b0;
                  next_s.timer_irq = 1'b1;
                end
                MODE_WAIT_ONE_SHOT: begin
                  if (s.phase == PH_PRIMARY) begin
                    next_s.phase = PH_SECONDARY;
                    next_s.tmr_cnt = next_s.sec_rel;
                  end else begin
                    next_s.phase = PH_PRIMARY;
                    next_s.tmr_cnt = next_s.pri_rel;
                    next_s.active = 1'b0;
                    next_s.timer_irq = 1'b1;
                  end
                end
                default: begin
                  next_s.tmr_cnt = next_s.pri_rel;
                  next_s.timer_irq = 1'b1;
                end
              endcase
            end
          end
        end
      end
    end

    // ----------------------------------------------------------------
    // Output pin, registered so it changes with the interrupt
    // ----------------------------------------------------------------
    wave_level = next_s.counting && (next_s.phase == PH_PRIMARY);
    pulse_level = next_s.active &&
                  ((next_s.mode == MODE_ONE_SHOT) ||
                   (next_s.phase == PH_SECONDARY));
    case (next_s.mode)
      MODE_WAVE: begin
        if (next_s.eff_switch) begin
          next_s.out_pin = next_s.port_latch;
        end else begin
          next_s.out_pin = wave_level ^
                           next_s.io.output_level_sel;
        end
      end
      MODE_ONE_SHOT, MODE_WAIT_ONE_SHOT:
        next_s.out_pin = pulse_level ^
                         next_s.io.output_level_sel;
      default: next_s.out_pin = next_s.port_latch;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

endmodule : tpg_one_shot_timer

// ===== tpg_one_shot_timer_bench.sv
// Self-checking bench for the one-shot pulse timer
`timescale 1ns/1ns
module tpg_one_shot_timer_bench
  import tpg_pkg::*;
;
  logic clk, rst, rd, wr, tick, lvl_req, pin, wreq, po, irq, pirq;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wd, rdat;
  logic [7:0] q;
  int n_fail, n_tests, cyc, pre, pri, sec, lv, wt, wdth, dv, dvf;
  logic [9:0] sti [3] = '{IDX_TIMER_RUN_CONTROL_REG,
    IDX_ONE_SHOT_CONTROL_REG, IDX_TIMER_RUN_CONTROL_REG};
  logic [7:0] std [3] = '{8'h04, 8'h02, 8'h00};

  tpg_one_shot_timer tpg_one_shot_timer_inst (
    .i_clk(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_ext_count_tick(tick), .i_ext_trigger_pin(pin),
    .o_pulse_output_pin(po), .o_timer_irq(irq), .o_pin_irq_request(pirq));
  tpg_trig_model tpg_trig_model_inst (
    .i_clk(clk), .i_rst(rst), .i_level(lvl_req), .o_pin(pin));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    tick <= 1'($urandom % 2);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  function automatic int span(int a, int b);
    return (a + 1) * (b + 1);
  endfunction : span
  task chk(string s, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task bus(logic w, logic [9:0] i, logic [7:0] d);
    int k;
    @(posedge clk);
    addr <= {i, 2'b00};
    rd <= !w;
    wr <= w;
    wd <= {24'h0, d};
    k = 0;
    // Waitrequest and read data are taken at the rising edge itself
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 40);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  // Settings go in while stopped so the counters load at once
  task arm(logic [7:0] md, logic [7:0] io);
    int k;
    bus(1'b1, IDX_TIMER_RUN_CONTROL_REG, 8'h00);
    bus(1'b1, IDX_MODE_REG, md);
    bus(1'b1, IDX_PRESCALER_SETTING, 8'(pre));
    bus(1'b1, IDX_PRIMARY_COUNT_SETTING, 8'(pri));
    bus(1'b1, IDX_SECONDARY_COUNT_SETTING, 8'(sec));
    bus(1'b0, IDX_PRIMARY_COUNT_SETTING, 8'h00);
    chk("primary counter", pri, q);
    bus(1'b1, IDX_TIMER_PIN_IO_CONTROL, io);
    bus(1'b1, IDX_TIMER_RUN_CONTROL_REG, 8'h01);
    k = 0;
    do begin
      bus(1'b0, IDX_TIMER_RUN_CONTROL_REG, 8'h00);
      k++;
    end while (q[COUNTING_STATUS_BIT] !== 1'b1 && k < 20);
  endtask : arm
  // Time to pulse start and pulse width, in clocks
  task pulse(int idle);
    int g;
    wt = 0;
    wdth = 0;
    g = 0;
    while (po === idle[0] && g < 3000) begin
      @(posedge clk);
      #1;
      wt++;
      g++;
    end
    while (po === !idle[0] && g < 3000) begin
      @(posedge clk);
      #1;
      wdth++;
      g++;
    end
    chk("irq at pulse end", 1, irq);
  endtask : pulse
  task quiet(int idle, int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (po !== idle[0]) bad++;
    end
    chk("pin stays idle", 0, bad);
  endtask : quiet
  task report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = '0;
    wd = '0;
    lvl_req = 1'b0;
    tick = 1'b0;
    cyc = 0;
    n_fail = 0;
    n_tests = 0;
    sec = 0;
    void'($urandom(68));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, IDX_TIMER_PIN_IO_CONTROL, 8'h00);
    chk("io reset", 8'h00, q);
    bus(1'b1, IDX_TIMER_PIN_IO_CONTROL, 8'hff);
    bus(1'b0, IDX_TIMER_PIN_IO_CONTROL, 8'h00);
    chk("io reserved", 8'h0f, q);
    bus(1'b1, 10'h3ff, 8'h55);
    bus(1'b0, 10'h3ff, 8'h00);
    chk("unmapped", 8'h00, q);
    for (lv = 0; lv < 2; lv++) begin
      bus(1'b1, IDX_MODE_REG, 8'h01);
      bus(1'b1, IDX_TIMER_PIN_IO_CONTROL, 8'(lv));
      repeat (2) @(negedge clk);
      chk("stopped level", lv, po);
    end
    $display("done: registers and stopped waveform");
    for (int i = 0; i < 6; i++) begin
      dv = (i < 4) ? 0 : i - 3;
      dvf = (dv == 2) ? 8 : dv + 1;
      pre = (i == 0) ? 0 : $urandom % 4;
      pri = (i == 0) ? 0 : $urandom % 8;
      lv = $urandom % 2;
      arm(8'(2 + 4 * dv), 8'(lv));
      chk("idle level", lv, po);
      bus(1'b1, IDX_ONE_SHOT_CONTROL_REG, 8'h01);
      // A second start in mid-pulse must neither restart nor stretch it
      fork
        pulse(lv);
        if (span(pre, pri) >= 8 && dv == 0)
          bus(1'b1, IDX_ONE_SHOT_CONTROL_REG, 8'h01);
      join
      chk("pulse width", span(pre, pri) * dvf, wdth);
      chk("start delay", 1, wt <= 2 * dvf);
      quiet(lv, 20);
      bus(1'b0, IDX_ONE_SHOT_CONTROL_REG, 8'h00);
      chk("active cleared", 0, q[ONE_SHOT_ACTIVE_BIT]);
    end
    $display("done: one-shot pulses");
    pre = 3;
    pri = 9;
    for (int s = 0; s < 3; s++) begin
      arm(8'h02, 8'h00);
      bus(1'b1, IDX_ONE_SHOT_CONTROL_REG, 8'h01);
      repeat (5) @(posedge clk);
      bus(1'b1, sti[s], std[s]);
      repeat ((s == 0) ? 1 : 3) @(negedge clk);
      chk("stopped pin", 0, po);
      bus(1'b0, IDX_PRIMARY_COUNT_SETTING, 8'h00);
      chk("reloaded count", pri, q);
      bus(1'b0, IDX_ONE_SHOT_CONTROL_REG, 8'h00);
      chk("active after stop", 0, q[ONE_SHOT_ACTIVE_BIT]);
    end
    bus(1'b1, IDX_ONE_SHOT_CONTROL_REG, 8'h01);
    quiet(0, 30);
    $display("done: stops");
    pri = 0;
    pre = 9;
    bus(1'b1, IDX_PIN_IRQ_CONTROL_REG, 8'h05);
    arm(8'h02, 8'h08);
    lvl_req <= 1'b1;
    quiet(0, 20);
    chk("flag on rise", 1, pirq);
    bus(1'b1, IDX_PIN_IRQ_CONTROL_REG, 8'h05);
    bus(1'b1, IDX_TIMER_PIN_IO_CONTROL, 8'h04);
    lvl_req <= 1'b0;
    pulse(0);
    chk("falling trigger", 10, wdth);
    chk("flag on fall", 0, pirq);
    bus(1'b1, IDX_TIMER_PIN_IO_CONTROL, 8'h0c);
    lvl_req <= 1'b1;
    fork
      pulse(0);
      begin
        bus(1'b1, IDX_PIN_IRQ_CONTROL_REG, 8'h05);
        lvl_req <= 1'b0;
        repeat (2) @(posedge clk);
        lvl_req <= 1'b1;
      end
    join
    chk("rising trigger", 10, wdth);
    chk("flag while active", 1, pirq);
    $display("done: pin trigger");
    for (int i = 0; i < 3; i++) begin
      pre = $urandom % 3;
      pri = $urandom % 6;
      sec = $urandom % 6;
      lv = $urandom % 2;
      arm(8'h03, 8'(lv));
      bus(1'b1, IDX_ONE_SHOT_CONTROL_REG, 8'h01);
      pulse(lv);
      chk("wait pulse", span(pre, sec), wdth);
      chk("wait time", 1, wt >= span(pre, pri) &&
        wt <= span(pre, pri) + 2);
    end
    $display("done: wait one-shot");
    report_and_stop();
  end
endmodule : tpg_one_shot_timer_bench

// ===== tpg_one_shot_timer_monitor.sv
// Port-level checker for the one-shot pulse timer
`timescale 1ns/1ns
module tpg_one_shot_timer_monitor
  import tpg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_ext_count_tick,
  input wire logic i_ext_trigger_pin,
  input wire logic o_pulse_output_pin,
  input wire logic o_timer_irq,
  input wire logic o_pin_irq_request
);
  logic [9:0] idx;
  logic mapped;
  logic clr;
  assign idx = i_avs_address[11:2];
  assign mapped = idx inside {[IDX_TIMER_RUN_CONTROL_REG:IDX_SHARED_PORT_LATCH],
    IDX_TIMER_PIN_IO_CONTROL};
  // Only a completed write to the pin irq register may drop the flag
  assign clr = i_avs_write && !o_avs_waitrequest &&
    idx == IDX_PIN_IRQ_CONTROL_REG;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_wait_first: assert property ($rose(i_avs_read || i_avs_write) |->
    o_avs_waitrequest) else $error("request answered without wait");
  a_wait_one: assert property ((i_avs_read || i_avs_write) &&
    o_avs_waitrequest |=> !o_avs_waitrequest) else $error("wait too long");
  a_rd_upper_zero: assert property (i_avs_read && !o_avs_waitrequest |->
    o_avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
  a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest &&
    !mapped |-> o_avs_readdata == 32'h0) else $error("hole reads nonzero");
  a_irq_one_clock: assert property (o_timer_irq |=> !o_timer_irq)
    else $error("timer irq longer than one clock");
  a_flag_holds: assert property (o_pin_irq_request && !clr |=>
    o_pin_irq_request) else $error("pin flag dropped");
  a_flag_edge_cause: assert property ($rose(o_pin_irq_request) |->
    $past(i_ext_trigger_pin) != $past(i_ext_trigger_pin, 2))
    else $error("pin flag without edge");
  a_reset_outputs: assert property ($past(i_rst) |-> !o_pulse_output_pin &&
    !o_timer_irq && !o_pin_irq_request && o_avs_readdata == 32'h0)
    else $error("outputs not at reset value");
  c_pulse_end: cover property (o_timer_irq);
  c_pin_flag: cover property ($rose(o_pin_irq_request));
  c_hole_read: cover property (i_avs_read && !o_avs_waitrequest && !mapped);
endmodule : tpg_one_shot_timer_monitor

bind tpg_one_shot_timer tpg_one_shot_timer_monitor tpg_monitor_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_ext_count_tick(i_ext_count_tick), .i_ext_trigger_pin(i_ext_trigger_pin),
  .o_pulse_output_pin(o_pulse_output_pin), .o_timer_irq(o_timer_irq),
  .o_pin_irq_request(o_pin_irq_request));

// ===== tpg_pkg.sv
// Constants, register map and state types of the one-shot pulse timer
package tpg_pkg;

  // ----------------------------------------------------------------
  // Register map (indices; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [9:0] IDX_TIMER_PIN_IO_CONTROL = 10'h10a;
  localparam logic [9:0] IDX_TIMER_RUN_CONTROL_REG = 10'h100;
  localparam logic [9:0] IDX_ONE_SHOT_CONTROL_REG = 10'h101;
  localparam logic [9:0] IDX_MODE_REG = 10'h102;
  localparam logic [9:0] IDX_PRESCALER_SETTING = 10'h103;
  localparam logic [9:0] IDX_PRIMARY_COUNT_SETTING = 10'h104;
  localparam logic [9:0] IDX_SECONDARY_COUNT_SETTING = 10'h105;
  localparam logic [9:0] IDX_PIN_IRQ_CONTROL_REG = 10'h106;
  localparam logic [9:0] IDX_SHARED_PORT_LATCH = 10'h107;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned RUN_REQUEST_BIT = 0;
  localparam int unsigned COUNTING_STATUS_BIT = 1;
  localparam int unsigned FORCED_HALT_BIT = 2;
  localparam int unsigned ONE_SHOT_START_BIT = 0;
  localparam int unsigned ONE_SHOT_STOP_BIT = 1;
  localparam int unsigned ONE_SHOT_ACTIVE_BIT = 2;
  localparam int unsigned PIN_IRQ_ENABLE_BIT = 0;
  localparam int unsigned BOTH_EDGES_BIT = 1;
  localparam int unsigned EDGE_DIRECTION_BIT = 2;
  localparam int unsigned REQUEST_PENDING_BIT = 3;

  // ----------------------------------------------------------------
  // Count source dividers
  // ----------------------------------------------------------------
  localparam logic [2:0] DIV2_LAST = 3'h1;
  localparam logic [2:0] DIV8_LAST = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_TIMER = 2'h0,
    MODE_WAVE = 2'h1,
    MODE_ONE_SHOT = 2'h2,
    MODE_WAIT_ONE_SHOT = 2'h3
  } tpg_mode_t;

  typedef enum logic [1:0] {
    PH_PRIMARY = 2'h1,
    PH_SECONDARY = 2'h2
  } tpg_phase_t;

  typedef enum logic [1:0] {
    SRC_F1 = 2'h0,
    SRC_F2 = 2'h1,
    SRC_F8 = 2'h2,
    SRC_EXT = 2'h3
  } tpg_src_t;

  typedef struct packed {
    logic [3:0] rsvd;
    logic pin_trigger_edge_sel;
    logic pin_trigger_enable;
    logic output_source_switch;
    logic output_level_sel;
  } tpg_io_ctrl_t;

  localparam tpg_io_ctrl_t IO_CTRL_RST = 8'h00;

  typedef struct packed {
    logic [7:0] pre_rel;
    logic [7:0] pre_cnt;
    logic [7:0] pri_rel;
    logic [7:0] sec_rel;
    logic [7:0] tmr_cnt;
    tpg_phase_t phase;
    tpg_mode_t mode;
    tpg_src_t src_sel;
    tpg_io_ctrl_t io;
    logic run;
    logic counting;
    logic active;
    logic trig_pend;
    logic stop_pend;
    logic port_latch;
    logic eff_switch;
    logic irq_en;
    logic both_edges;
    logic edge_dir;
    logic irq_pending;
    logic [2:0] div_cnt;
    logic pin_prev;
    logic timer_irq;
    logic out_pin;
    logic ack;
    logic [31:0] rdata;
  } tpg_state_t;

  localparam tpg_state_t STATE_RST = '{
    phase: PH_PRIMARY,
    mode: MODE_TIMER,
    src_sel: SRC_F1,
    io: IO_CTRL_RST,
    default: '0
  };

endpackage : tpg_pkg

// ===== tpg_trig_model.sv
// Outside trigger source feeding the timer's trigger pin
`timescale 1ns/1ns
module tpg_trig_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_level,
  output logic o_pin
);
  // Pin moves only on a clock edge, so each level change is one clean edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pin <= 1'b0;
    end else begin
      o_pin <= i_level;
    end
  end
endmodule : tpg_trig_model
